// [dtc_pkg.sv]
// Constants, types and register map of the dual timer/counter.
package dtc_pkg;

  typedef logic [7:0] dtc_addr_t;
  typedef logic [7:0] dtc_byte_t;

  typedef enum logic [1:0] {
    DTC_MODE_13BIT  = 2'h0,
    DTC_MODE_16BIT  = 2'h1,
    DTC_MODE_RELOAD = 2'h2,
    DTC_MODE_SPLIT  = 2'h3
  } dtc_mode_t;

  typedef enum logic [2:0] {
    DTC_SEL_NONE,
    DTC_SEL_CTRL,
    DTC_SEL_MODE,
    DTC_SEL_LO_A,
    DTC_SEL_LO_B,
    DTC_SEL_HI_A,
    DTC_SEL_HI_B
  } dtc_sel_t;

  localparam dtc_addr_t DTC_ADDR_CTRL = 8'h88;
  localparam dtc_addr_t DTC_ADDR_MODE = 8'h89;
  localparam dtc_addr_t DTC_ADDR_LO_A = 8'h8A;
  localparam dtc_addr_t DTC_ADDR_LO_B = 8'h8B;
  localparam dtc_addr_t DTC_ADDR_HI_A = 8'h8C;
  localparam dtc_addr_t DTC_ADDR_HI_B = 8'h8D;

  localparam dtc_byte_t DTC_RST_CTRL  = 8'h00;
  localparam dtc_byte_t DTC_RST_MODE  = 8'h00;
  localparam dtc_byte_t DTC_RST_COUNT = 8'h00;
  localparam dtc_byte_t DTC_READ_IDLE = 8'h00;

  // Control register fields, per unit u (0 = A, 1 = B).
  localparam int DTC_CTRL_TYPE_LSB = 0;
  localparam int DTC_CTRL_EXT_LSB  = 1;
  localparam int DTC_CTRL_RUN_LSB  = 4;
  localparam int DTC_CTRL_OVF_LSB  = 5;
  localparam int DTC_CTRL_STRIDE   = 2;

  // Mode register fields, per unit u at base u * DTC_MODE_STRIDE.
  localparam int DTC_MODE_FIELD_LSB = 0;
  localparam int DTC_MODE_CT_BIT    = 2;
  localparam int DTC_MODE_GATE_BIT  = 3;
  localparam int DTC_MODE_STRIDE    = 4;

  // Machine cycle timing.
  localparam int         DTC_OSC_PER_MC = 12;
  localparam logic [3:0] DTC_MC_LAST    = 4'(DTC_OSC_PER_MC - 1);
  localparam logic [3:0] DTC_MC_RST     = 4'h0;
  // Pins idle high; a low reset value would look like a level or edge event.
  localparam logic [3:0] DTC_PIN_IDLE   = 4'hF;

  localparam logic [4:0] DTC_PRESC_FULL = 5'h1F;
  localparam dtc_byte_t  DTC_BYTE_FULL  = 8'hFF;

endpackage : dtc_pkg

// [dtc_cnt_if.sv]
// Signals between the control logic and one count unit.
`timescale 1ns/10ps
interface dtc_cnt_if;
  import dtc_pkg::*;

  dtc_mode_t mode;
  logic      ct;
  logic      gate;
  logic      run;
  logic      gate_lvl;
  logic      tick;
  logic      fall;
  logic      hi_run;
  logic      wr_lo;
  logic      wr_hi;
  dtc_byte_t wdata;
  dtc_byte_t lo;
  dtc_byte_t hi;
  logic      ovf;
  logic      ovf_hi;

  modport unit (
    input  mode, ct, gate, run, gate_lvl, tick, fall, hi_run, wr_lo, wr_hi, wdata,
    output lo, hi, ovf, ovf_hi
  );

  modport ctrl (
    output mode, ct, gate, run, gate_lvl, tick, fall, hi_run, wr_lo, wr_hi, wdata,
    input  lo, hi, ovf, ovf_hi
  );

endinterface : dtc_cnt_if

// [dtc_count_unit.sv]
// One 16-bit count unit with its four modes.
`timescale 1ns/10ps
module dtc_count_unit #(
  parameter bit SPLIT_OK = 1'b1
) (
  input  wire logic   ref_clk_i,
  input  wire logic   rst_i,
  dtc_cnt_if.unit     cnt
);
  import dtc_pkg::*;

  logic      enable;
  logic      inc;
  logic      hi_inc;
  dtc_byte_t next_lo;
  dtc_byte_t next_hi;
  dtc_byte_t lo;
  dtc_byte_t hi;

  always_comb begin
    enable      = cnt.run & (~cnt.gate | cnt.gate_lvl);
    inc         = enable & (cnt.ct ? cnt.fall : cnt.tick);
    hi_inc      = cnt.tick & cnt.hi_run;
    next_lo     = lo;
    next_hi     = hi;
    cnt.ovf     = 1'b0;
    cnt.ovf_hi  = 1'b0;
    case (cnt.mode)
      DTC_MODE_13BIT: begin
        if (inc) begin
          // Upper three low bits are left alone; software must ignore them.
          next_lo = {lo[7:5], 5'(lo[4:0] + 5'h01)};
          if (lo[4:0] == DTC_PRESC_FULL) begin
            next_hi = 8'(hi + 8'h01);
            cnt.ovf = (hi == DTC_BYTE_FULL);
          end
        end
      end
      DTC_MODE_16BIT: begin
        if (inc) begin
          {next_hi, next_lo} = 16'({hi, lo} + 16'h0001);
          cnt.ovf = ({hi, lo} == {DTC_BYTE_FULL, DTC_BYTE_FULL});
        end
      end
      DTC_MODE_RELOAD: begin
        // Unit B has no reload mode and holds still here.
        if (SPLIT_OK && inc) begin
          if (lo == DTC_BYTE_FULL) begin
            next_lo = hi;
            cnt.ovf = 1'b1;
          end else begin
            next_lo = 8'(lo + 8'h01);
          end
        end
      end
      default: begin
        // Split on unit A; on unit B this encoding halts the count.
        if (SPLIT_OK) begin
          if (inc) begin
            next_lo = 8'(lo + 8'h01);
            cnt.ovf = (lo == DTC_BYTE_FULL);
          end
          if (hi_inc) begin
            next_hi    = 8'(hi + 8'h01);
            cnt.ovf_hi = (hi == DTC_BYTE_FULL);
          end
        end
      end
    endcase
  end

  // A software write to a byte wins over a count in the same cycle.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lo <= DTC_RST_COUNT;
    end else begin
      lo <= cnt.wr_lo ? cnt.wdata : next_lo;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hi <= DTC_RST_COUNT;
    end else begin
      hi <= cnt.wr_hi ? cnt.wdata : next_hi;
    end
  end

  assign cnt.lo = lo;
  assign cnt.hi = hi;

endmodule : dtc_count_unit

// [dtc_top.sv]
// Dual timer/counter: register port, pin sampling, flags and two count units.
//
// Function
// - Timer function counts one per machine cycle of twelve oscillator periods.
// - Counter function samples event pin each machine cycle, counts high-then-low.
// - New count shows in the machine cycle after the falling edge is seen.
// - Edge recognition spans two machine cycles; peak rate is clock over 24.
// - 13-bit mode uses high byte plus low five bits; upper three undefined.
// - Rollover from all ones to zeros sets unit overflow flag and requests interrupt.
// - Unit counts only with run bit set and gating off or gate pin high.
// - Setting run bit keeps count bytes; counting resumes from held value.
// - 16-bit mode cascades both bytes fully, no prescaler.
// - Unit A reload mode: low overflow sets flag, copies high into low.
// - Unit A split: low byte under A controls; high byte times on B run, flag.
// - Unit B in split encoding stops counting.
// - Unit B reload mode is not implemented.
// - Each unit B overflow sends one pulse to the serial port.
// - Source select clear picks machine cycles; set picks event pin.
// - Mode field: 00 13-bit, 01 16-bit, 10 auto-reload, 11 split or stopped.
// - Mode and run-bit writes take effect at end of the current machine cycle; flag and type bits change at once.
// - Gate pins keep their normal external interrupt function in every mode.
// - Overflow flags set on overflow, cleared by hardware when vectoring.
// - Control register at 88: ovf B, run B, ovf A, run A, ext B, type B, ext A, type A.
// - External flag set on detected edge, cleared when processed; type picks edge or level.
`timescale 1ns/10ps
module dtc_top (
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  input  wire dtc_pkg::dtc_addr_t reg_addr_i,
  input  wire dtc_pkg::dtc_byte_t reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output      dtc_pkg::dtc_byte_t reg_rdata_o,
  input  wire logic              event_pin_a_i,
  input  wire logic              event_pin_b_i,
  input  wire logic              gate_input_a_i,
  input  wire logic              gate_input_b_i,
  input  wire logic              ovf_vector_a_i,
  input  wire logic              ovf_vector_b_i,
  input  wire logic              ext_vector_a_i,
  input  wire logic              ext_vector_b_i,
  output logic                   overflow_irq_a_o,
  output logic                   overflow_irq_b_o,
  output logic                   ext_irq_a_o,
  output logic                   ext_irq_b_o,
  output logic                   serial_baud_tick_o
);
  import dtc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////////////////

  function automatic dtc_sel_t reg_decode(input dtc_addr_t addr);
    case (addr)
      DTC_ADDR_CTRL: reg_decode = DTC_SEL_CTRL;
      DTC_ADDR_MODE: reg_decode = DTC_SEL_MODE;
      DTC_ADDR_LO_A: reg_decode = DTC_SEL_LO_A;
      DTC_ADDR_LO_B: reg_decode = DTC_SEL_LO_B;
      DTC_ADDR_HI_A: reg_decode = DTC_SEL_HI_A;
      DTC_ADDR_HI_B: reg_decode = DTC_SEL_HI_B;
      default:       reg_decode = DTC_SEL_NONE;
    endcase
  endfunction : reg_decode

  //////////////////////////////////////////////////////////////////////////////////////////

  logic [3:0] mc_cnt;
  logic       mc_tick;
  logic       tick_d;
  logic [3:0] pin_raw;
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic [3:0] pin_smp;
  logic [3:0] fall_pulse;
  dtc_byte_t  mode_reg;
  dtc_byte_t  eff_mode;
  logic [1:0] run_bit;
  logic [1:0] eff_run;
  logic [1:0] ovf_flag;
  logic [1:0] ext_flag;
  logic [1:0] ext_type;
  logic [1:0] ovf_vector;
  logic [1:0] ext_vector;
  logic [1:0] set_ovf;
  logic [1:0] unit_ovf;
  logic       a_split;
  dtc_sel_t   wr_sel;
  dtc_byte_t  ctrl_view;
  dtc_byte_t  next_rdata;
  dtc_byte_t  cnt_lo [2];
  dtc_byte_t  cnt_hi [2];
  logic       hi_ovf_a;

  assign pin_raw    = {gate_input_b_i, gate_input_a_i, event_pin_b_i, event_pin_a_i};
  assign ovf_vector = {ovf_vector_b_i, ovf_vector_a_i};
  assign ext_vector = {ext_vector_b_i, ext_vector_a_i};
  assign wr_sel     = reg_wr_i ? reg_decode(reg_addr_i) : DTC_SEL_NONE;

  //////////////////////////////////////////////////////////////////////////////////////////
  // Machine cycle generator.

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mc_cnt <= DTC_MC_RST;
    end else if (mc_cnt == DTC_MC_LAST) begin
      mc_cnt <= DTC_MC_RST;
    end else begin
      mc_cnt <= 4'(mc_cnt + 4'h1);
    end
  end

  assign mc_tick = (mc_cnt == DTC_MC_LAST);

  // Delayed tick lines up timer counting with the registered edge pulse.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_d <= 1'b0;
    end else begin
      tick_d <= mc_tick;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and once-per-machine-cycle sampling.

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_meta <= DTC_PIN_IDLE;
      pin_sync <= DTC_PIN_IDLE;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  // A pulse shorter than one machine cycle may be missed entirely.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_smp <= DTC_PIN_IDLE;
    end else if (mc_tick) begin
      pin_smp <= pin_sync;
    end
  end

  // High in the last sample and low in this one: one edge, one count.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fall_pulse <= 4'h0;
    end else begin
      fall_pulse <= mc_tick ? (pin_smp & ~pin_sync) : 4'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Software-visible mode and run bits, and their effective copies.

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_reg <= DTC_RST_MODE;
    end else if (wr_sel == DTC_SEL_MODE) begin
      mode_reg <= reg_wdata_i;
    end
  end

  // Run bits only gate counting; they never touch the count bytes.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      run_bit <= 2'h0;
    end else if (wr_sel == DTC_SEL_CTRL) begin
      for (int u = 0; u < 2; u++) begin
        run_bit[u] <= reg_wdata_i[DTC_CTRL_RUN_LSB + u * DTC_CTRL_STRIDE];
      end
    end
  end

  // Changes reach the counters only at the close of the machine cycle.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      eff_mode <= DTC_RST_MODE;
      eff_run  <= 2'h0;
    end else if (mc_tick) begin
      eff_mode <= mode_reg;
      eff_run  <= run_bit;
    end
  end

  assign a_split = (dtc_mode_t'(eff_mode[DTC_MODE_FIELD_LSB +: 2]) == DTC_MODE_SPLIT);

  //////////////////////////////////////////////////////////////////////////////////////////
  // Count units.

  for (genvar u = 0; u < 2; u++) begin : g_unit
    dtc_cnt_if cnt_bus ();

    assign cnt_bus.mode     = dtc_mode_t'(eff_mode[u * DTC_MODE_STRIDE + DTC_MODE_FIELD_LSB +: 2]);
    assign cnt_bus.ct       = eff_mode[u * DTC_MODE_STRIDE + DTC_MODE_CT_BIT];
    assign cnt_bus.gate     = eff_mode[u * DTC_MODE_STRIDE + DTC_MODE_GATE_BIT];
    assign cnt_bus.gate_lvl = pin_smp[2 + u];
    assign cnt_bus.tick     = tick_d;
    assign cnt_bus.fall     = fall_pulse[u];
    assign cnt_bus.wdata    = reg_wdata_i;
    assign cnt_bus.wr_lo    = (wr_sel == ((u == 0) ? DTC_SEL_LO_A : DTC_SEL_LO_B));
    assign cnt_bus.wr_hi    = (wr_sel == ((u == 0) ? DTC_SEL_HI_A : DTC_SEL_HI_B));
    if (u == 0) begin : g_a
      assign cnt_bus.run    = eff_run[0];
      assign cnt_bus.hi_run = eff_run[1];
    end else begin : g_b
      // With A split, B lost its run bit and runs until put in reload or split encoding.
      assign cnt_bus.run    = a_split | eff_run[1];
      assign cnt_bus.hi_run = 1'b0;
    end

    dtc_count_unit #(
      .SPLIT_OK (u == 0)
    ) u_count (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .cnt       (cnt_bus.unit)
    );

    assign cnt_lo[u]   = cnt_bus.lo;
    assign cnt_hi[u]   = cnt_bus.hi;
    assign unit_ovf[u] = cnt_bus.ovf;
    if (u == 0) begin : g_hi_ovf
      assign hi_ovf_a = cnt_bus.ovf_hi;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Overflow flags and serial pulse.

  assign set_ovf[0] = unit_ovf[0];
  assign set_ovf[1] = a_split ? hi_ovf_a : unit_ovf[1];

  // Hardware set beats both the vector clear and a software write.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ovf_flag <= 2'h0;
    end else begin
      for (int u = 0; u < 2; u++) begin
        if (set_ovf[u]) begin
          ovf_flag[u] <= 1'b1;
        end else if (ovf_vector[u]) begin
          ovf_flag[u] <= 1'b0;
        end else if (wr_sel == DTC_SEL_CTRL) begin
          ovf_flag[u] <= reg_wdata_i[DTC_CTRL_OVF_LSB + u * DTC_CTRL_STRIDE];
        end
      end
    end
  end

  // Unit B overflows pace the serial port even when its flag is lent out.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      serial_baud_tick_o <= 1'b0;
    end else begin
      serial_baud_tick_o <= unit_ovf[1];
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // External interrupt flags on the gate pins, independent of counting.

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_type <= 2'h0;
    end else if (wr_sel == DTC_SEL_CTRL) begin
      for (int u = 0; u < 2; u++) begin
        ext_type[u] <= reg_wdata_i[DTC_CTRL_TYPE_LSB + u * DTC_CTRL_STRIDE];
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_flag <= 2'h0;
    end else begin
      for (int u = 0; u < 2; u++) begin
        if (!ext_type[u]) begin
          ext_flag[u] <= ~pin_smp[2 + u];
        end else if (fall_pulse[2 + u]) begin
          ext_flag[u] <= 1'b1;
        end else if (ext_vector[u]) begin
          ext_flag[u] <= 1'b0;
        end else if (wr_sel == DTC_SEL_CTRL) begin
          ext_flag[u] <= reg_wdata_i[DTC_CTRL_EXT_LSB + u * DTC_CTRL_STRIDE];
        end
      end
    end
  end

  assign overflow_irq_a_o = ovf_flag[0];
  assign overflow_irq_b_o = ovf_flag[1];
  assign ext_irq_a_o      = ext_flag[0];
  assign ext_irq_b_o      = ext_flag[1];

  //////////////////////////////////////////////////////////////////////////////////////////
  // Register read port.

  assign ctrl_view = {ovf_flag[1], run_bit[1], ovf_flag[0], run_bit[0],
                      ext_flag[1], ext_type[1], ext_flag[0], ext_type[0]};

  always_comb begin
    case (reg_decode(reg_addr_i))
      DTC_SEL_CTRL: next_rdata = ctrl_view;
      DTC_SEL_MODE: next_rdata = mode_reg;
      DTC_SEL_LO_A: next_rdata = cnt_lo[0];
      DTC_SEL_LO_B: next_rdata = cnt_lo[1];
      DTC_SEL_HI_A: next_rdata = cnt_hi[0];
      DTC_SEL_HI_B: next_rdata = cnt_hi[1];
      default:      next_rdata = DTC_READ_IDLE;
    endcase
  end

  // Data is valid only in the cycle after the read strobe.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= DTC_READ_IDLE;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end else begin
      reg_rdata_o <= DTC_READ_IDLE;
    end
  end

endmodule : dtc_top

// [dtc_pins_model.sv]
// Far-side model: event pins, gate pins and a serial port that counts baud ticks.
`timescale 1ns/10ps
module dtc_pins_model (
  input  wire logic ref_clk_i,
  input  wire logic serial_baud_tick_i,
  output logic      event_pin_a_o,
  output logic      event_pin_b_o,
  output logic      gate_input_a_o,
  output logic      gate_input_b_o,
  output int        baud_cnt_o
);
  import dtc_pkg::*;

  initial begin
    event_pin_a_o  = 1'b1;
    event_pin_b_o  = 1'b1;
    gate_input_a_o = 1'b1;
    gate_input_b_o = 1'b1;
    baud_cnt_o     = 0;
  end

  // The serial port only counts pulses; bit rate division is outside this block.
  always @(posedge ref_clk_i) begin
    if (serial_baud_tick_i === 1'b1) begin
      baud_cnt_o <= baud_cnt_o + 1;
    end
  end

  task set_gate(input int u, input logic lvl);
    @(posedge ref_clk_i);
    if (u == 0) begin
      gate_input_a_o <= lvl;
    end else begin
      gate_input_b_o <= lvl;
    end
  endtask : set_gate

  // Each level is held one full machine cycle, the fastest legal edge rate.
  task pulse(input int u, input int n);
    repeat (n) begin
      @(posedge ref_clk_i);
      if (u == 0) begin
        event_pin_a_o <= 1'b0;
      end else begin
        event_pin_b_o <= 1'b0;
      end
      repeat (DTC_OSC_PER_MC) @(posedge ref_clk_i);
      event_pin_a_o <= 1'b1;
      event_pin_b_o <= 1'b1;
      repeat (DTC_OSC_PER_MC - 1) @(posedge ref_clk_i);
    end
  endtask : pulse
endmodule : dtc_pins_model

// [dtc_top_assertions.sv]
// Checker of the dual timer/counter port behaviour.
`timescale 1ns/10ps
module dtc_top_assertions (
  input wire logic               ref_clk_i,
  input wire logic               rst_i,
  input wire dtc_pkg::dtc_addr_t reg_addr_i,
  input wire logic               reg_wr_i,
  input wire logic               reg_rd_i,
  input wire dtc_pkg::dtc_byte_t reg_rdata_o,
  input wire logic               gate_input_a_i,
  input wire logic               ovf_vector_a_i,
  input wire logic               ovf_vector_b_i,
  input wire logic               ext_vector_a_i,
  input wire logic               overflow_irq_a_o,
  input wire logic               overflow_irq_b_o,
  input wire logic               ext_irq_a_o,
  input wire logic               ext_irq_b_o,
  input wire logic               serial_baud_tick_o
);
  import dtc_pkg::*;

  // Cycles since the gate pin was last high; a level flag may only drop soon after.
  logic [4:0] high_age;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      high_age <= 5'h00;
    end else if (gate_input_a_i) begin
      high_age <= 5'h00;
    end else if (high_age != 5'h1F) begin
      high_age <= high_age + 5'h01;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_read_idle_zero: assert property (!$past(reg_rd_i) |-> reg_rdata_o == DTC_READ_IDLE)
    else $error("read data outside the answer cycle");
  a_flags_readback: assert property (reg_rd_i && reg_addr_i == DTC_ADDR_CTRL |=>
    reg_rdata_o[7] == $past(overflow_irq_b_o) && reg_rdata_o[5] == $past(overflow_irq_a_o) &&
    reg_rdata_o[3] == $past(ext_irq_b_o) && reg_rdata_o[1] == $past(ext_irq_a_o))
    else $error("control read disagrees with flag outputs");
  a_unmapped_zero: assert property (reg_rd_i && (reg_addr_i < DTC_ADDR_CTRL || reg_addr_i > DTC_ADDR_HI_B)
    |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_baud_single: assert property (serial_baud_tick_o |=> !serial_baud_tick_o [*8])
    else $error("baud pulse too long or too close");
  a_ovf_a_clear: assert property ($fell(overflow_irq_a_o) |-> $past(ovf_vector_a_i) || $past(reg_wr_i))
    else $error("overflow flag A dropped without cause");
  a_ovf_b_clear: assert property ($fell(overflow_irq_b_o) |-> $past(ovf_vector_b_i) || $past(reg_wr_i))
    else $error("overflow flag B dropped without cause");
  a_ovf_b_hold: assert property (overflow_irq_b_o && !ovf_vector_b_i && !reg_wr_i |=> overflow_irq_b_o)
    else $error("overflow flag B did not hold");
  a_ext_a_release: assert property ($fell(ext_irq_a_o) |->
    $past(ext_vector_a_i) || $past(reg_wr_i) || high_age < 5'h14)
    else $error("external flag A dropped without cause");
endmodule : dtc_top_assertions

bind dtc_top dtc_top_assertions dtc_top_assertions_i (
  .ref_clk_i          (ref_clk_i),
  .rst_i              (rst_i),
  .reg_addr_i         (reg_addr_i),
  .reg_wr_i           (reg_wr_i),
  .reg_rd_i           (reg_rd_i),
  .reg_rdata_o        (reg_rdata_o),
  .gate_input_a_i     (gate_input_a_i),
  .ovf_vector_a_i     (ovf_vector_a_i),
  .ovf_vector_b_i     (ovf_vector_b_i),
  .ext_vector_a_i     (ext_vector_a_i),
  .overflow_irq_a_o   (overflow_irq_a_o),
  .overflow_irq_b_o   (overflow_irq_b_o),
  .ext_irq_a_o        (ext_irq_a_o),
  .ext_irq_b_o        (ext_irq_b_o),
  .serial_baud_tick_o (serial_baud_tick_o)
);

// [dual_timer_counter_tb.sv]
// Testbench of the dual timer/counter: register tasks and scenario sequences.
`timescale 1ns/10ps
module dual_timer_counter_tb;
  import dtc_pkg::*;

  logic      ref_clk_i;
  logic      rst_i;
  dtc_addr_t reg_addr_i;
  dtc_byte_t reg_wdata_i;
  logic      reg_wr_i;
  logic      reg_rd_i;
  dtc_byte_t reg_rdata_o;
  logic      [1:0] ovf_vec;
  logic      [1:0] ext_vec;
  logic      ev_a, ev_b, gt_a, gt_b, baud;
  wire       [3:0] irq;
  int        baud_cnt;
  int        error_cnt;
  int        checked;
  int        cycles;
  dtc_byte_t v;

  dtc_top dtc_top_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .event_pin_a_i(ev_a), .event_pin_b_i(ev_b), .gate_input_a_i(gt_a), .gate_input_b_i(gt_b),
    .ovf_vector_a_i(ovf_vec[0]), .ovf_vector_b_i(ovf_vec[1]), .ext_vector_a_i(ext_vec[0]),
    .ext_vector_b_i(ext_vec[1]), .overflow_irq_a_o(irq[2]), .overflow_irq_b_o(irq[3]),
    .ext_irq_a_o(irq[0]), .ext_irq_b_o(irq[1]), .serial_baud_tick_o(baud));

  dtc_pins_model dtc_pins_model_i (.ref_clk_i(ref_clk_i), .serial_baud_tick_i(baud), .event_pin_a_o(ev_a),
    .event_pin_b_o(ev_b), .gate_input_a_o(gt_a), .gate_input_b_o(gt_b), .baud_cnt_o(baud_cnt));

  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task end_of_test;
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  task check(input string name, input dtc_byte_t seen, input dtc_byte_t exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task wr(input dtc_addr_t a, input dtc_byte_t d);
    @(posedge ref_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i    <= 1'b0;
  endtask : wr

  // Reads one byte and accepts any value from lo to hi, since ticks may straddle a write.
  task rd_rng(input string name, input dtc_addr_t a, input dtc_byte_t lo, input dtc_byte_t hi);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i   <= 1'b0;
    #1;
    v = reg_rdata_o;
    check(name, (v >= lo && v <= hi) ? lo : v, lo);
  endtask : rd_rng

  task wait_irq(input int i, input logic lvl, input int lim);
    int k;
    k = 0;
    while (irq[i] !== lvl && k < lim) begin
      @(posedge ref_clk_i);
      #1;
      k++;
    end
    check("irq", {7'h00, irq[i]}, {7'h00, lvl});
  endtask : wait_irq

  task vec(input logic ovf, input int u);
    @(posedge ref_clk_i);
    if (ovf) begin
      ovf_vec[u] <= 1'b1;
    end else begin
      ext_vec[u] <= 1'b1;
    end
    @(posedge ref_clk_i);
    ovf_vec <= 2'h0;
    ext_vec <= 2'h0;
  endtask : vec

  task idle(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : idle

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  initial begin
    rst_i = 1'b1;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    ovf_vec = 2'h0;
    ext_vec = 2'h0;
    error_cnt = 0;
    checked = 0;
    cycles = 0;
    idle(8);
    rst_i <= 1'b0;
    for (int a = 8'h88; a <= 8'h8D; a++) rd_rng("reset", 8'(a), 8'h00, 8'h00);
    wr(8'h90, 8'hFF);
    rd_rng("unmapped", 8'h90, 8'h00, 8'h00);
    wr(DTC_ADDR_MODE, 8'hA5);
    rd_rng("mode", DTC_ADDR_MODE, 8'hA5, 8'hA5);
    wr(DTC_ADDR_MODE, 8'h01);
    wr(DTC_ADDR_LO_A, 8'h00);
    wr(DTC_ADDR_CTRL, 8'h10);
    idle(120);
    wr(DTC_ADDR_CTRL, 8'h00);
    idle(24);
    rd_rng("timer rate", DTC_ADDR_LO_A, 8'h09, 8'h0B);
    wr(DTC_ADDR_HI_A, 8'hFF);
    wr(DTC_ADDR_LO_A, 8'hFE);
    wr(DTC_ADDR_CTRL, 8'h10);
    wait_irq(2, 1'b1, 60);
    rd_rng("wrap high", DTC_ADDR_HI_A, 8'h00, 8'h00);
    rd_rng("flags", DTC_ADDR_CTRL, 8'h30, 8'h30);
    vec(1'b1, 0);
    wait_irq(2, 1'b0, 4);
    // A start of 1E tells 13-bit from 16-bit: only the prescaler carries into high.
    wr(DTC_ADDR_MODE, 8'h00);
    wr(DTC_ADDR_HI_A, 8'h00);
    wr(DTC_ADDR_LO_A, 8'h1E);
    idle(24);
    idle(24);
    wr(DTC_ADDR_CTRL, 8'h00);
    idle(24);
    rd_rng("presc high", DTC_ADDR_HI_A, 8'h01, 8'h01);
    rd_rng("presc low", DTC_ADDR_LO_A, 8'h01, 8'h03);
    wr(DTC_ADDR_MODE, 8'h02);
    wr(DTC_ADDR_HI_A, 8'hF0);
    wr(DTC_ADDR_LO_A, 8'hFE);
    wr(DTC_ADDR_CTRL, 8'h10);
    wait_irq(2, 1'b1, 60);
    wr(DTC_ADDR_CTRL, 8'h00);
    idle(24);
    rd_rng("reload high", DTC_ADDR_HI_A, 8'hF0, 8'hF0);
    rd_rng("reload low", DTC_ADDR_LO_A, 8'hF0, 8'hF2);
    vec(1'b1, 0);
    wr(DTC_ADDR_MODE, 8'h09);
    wr(DTC_ADDR_LO_A, 8'h00);
    dtc_pins_model_i.set_gate(0, 1'b0);
    wr(DTC_ADDR_CTRL, 8'h10);
    idle(120);
    rd_rng("gated off", DTC_ADDR_LO_A, 8'h00, 8'h00);
    dtc_pins_model_i.set_gate(0, 1'b1);
    idle(120);
    wr(DTC_ADDR_CTRL, 8'h00);
    idle(24);
    rd_rng("gated on", DTC_ADDR_LO_A, 8'h09, 8'h0B);
    wr(DTC_ADDR_MODE, 8'h50);
    wr(DTC_ADDR_LO_B, 8'h00);
    wr(DTC_ADDR_CTRL, 8'h40);
    idle(36);
    dtc_pins_model_i.pulse(1, 5);
    idle(24);
    wr(DTC_ADDR_CTRL, 8'h00);
    idle(24);
    rd_rng("events", DTC_ADDR_LO_B, 8'h05, 8'h05);
    wr(DTC_ADDR_MODE, 8'h10);
    wr(DTC_ADDR_HI_B, 8'hFF);
    wr(DTC_ADDR_LO_B, 8'hFE);
    wr(DTC_ADDR_CTRL, 8'h40);
    wait_irq(3, 1'b1, 60);
    idle(2);
    check("baud", 8'(baud_cnt), 8'h01);
    vec(1'b1, 1);
    wait_irq(3, 1'b0, 4);
    for (int m = 2; m <= 3; m++) begin
      wr(DTC_ADDR_MODE, 8'(m << 4));
      idle(24);
      wr(DTC_ADDR_LO_B, 8'h00);
      idle(60);
      rd_rng("b stopped", DTC_ADDR_LO_B, 8'h00, 8'h00);
    end
    wr(DTC_ADDR_CTRL, 8'h00);
    wr(DTC_ADDR_MODE, 8'h33);
    wr(DTC_ADDR_LO_A, 8'h55);
    wr(DTC_ADDR_HI_A, 8'hFE);
    wr(DTC_ADDR_CTRL, 8'h40);
    wait_irq(3, 1'b1, 60);
    check("split flag a", {7'h00, irq[2]}, 8'h00);
    rd_rng("split low", DTC_ADDR_LO_A, 8'h55, 8'h55);
    vec(1'b1, 1);
    for (int u = 0; u < 2; u++) begin
      wr(DTC_ADDR_CTRL, 8'(1 << (2 * u)));
      idle(24);
      dtc_pins_model_i.set_gate(u, 1'b0);
      wait_irq(u, 1'b1, 40);
      dtc_pins_model_i.set_gate(u, 1'b1);
      idle(30);
      wait_irq(u, 1'b1, 1);
      vec(1'b0, u);
      wait_irq(u, 1'b0, 4);
      wr(DTC_ADDR_CTRL, 8'h00);
      idle(24);
      dtc_pins_model_i.set_gate(u, 1'b0);
      wait_irq(u, 1'b1, 40);
      dtc_pins_model_i.set_gate(u, 1'b1);
      wait_irq(u, 1'b0, 40);
    end
    end_of_test();
  end
endmodule : dual_timer_counter_tb
